// *** hw/serial_unit_defs.svh ***
// constants of the universal serial unit: reset values, counts and fifo sizes
`ifndef SERIAL_UNIT_DEFS_SVH
`define SERIAL_UNIT_DEFS_SVH

`define SHIFT_DATA_RESET   8'h00
`define DATA_MSB           7
`define COUNT_RESET        4'h0
`define COUNT_LAST_EDGE    4'hf
`define ACK_PRELOAD        4'he
`define PORT_BIT_RESET     1'b1
`define DIRECTION_RESET    1'b0
`define RX_FIFO_WIDTH      8
`define RX_FIFO_DEPTH      8

`endif

// *** hw/serial_unit_pkg.sv ***
// types shared by the universal serial unit
package serial_unit_pkg;

   // wire_mode_select settings of the unit
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_THREE_WIRE,
      MODE_TWO_WIRE
   } wire_mode_t;

   // start detector clock-hold sequence
   typedef enum logic [1:0] {
      START_IDLE,
      START_WAIT_FALL,
      START_HOLD
   } start_state_t;

endpackage

// *** hw/universal_serial_unit.sv ***
// universal serial unit: shift register, edge counter, start detector, clock stretch and rx fifo
`timescale 1ns/100ps
`include "serial_unit_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// receive fifo with valid/ready on both sides
module byte_fifo #(
   parameter int WIDTH = `RX_FIFO_WIDTH,
   parameter int DEPTH = `RX_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    fill;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == LAST_SLOT) ? '0 : p + 1'b1;
   endfunction

   assign in_ready  = (fill != FULL_COUNT);
   assign out_valid = (fill != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= bump(wr_ptr);
         if (pop)
            rd_ptr <= bump(rd_ptr);
         if (push && !pop)
            fill <= fill + 1'b1;
         else if (pop && !push)
            fill <= fill - 1'b1;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module universal_serial_unit (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  serial_unit_pkg::wire_mode_t    wire_mode_select,
   input  wire logic                      clock_source_select,
   input  wire logic                      negative_sample_edge,
   input  wire logic [7:0]                shift_load_data,
   input  wire logic                      shift_load,
   input  wire logic [3:0]                counter_load_value,
   input  wire logic                      counter_load,
   input  wire logic                      start_flag_clear,
   input  wire logic                      overflow_flag_clear,
   input  wire logic                      data_port_bit,
   input  wire logic                      data_direction_bit,
   input  wire logic                      clock_port_write,
   input  wire logic                      clock_port_value,
   input  wire logic                      clock_port_toggle,
   input  wire logic                      clock_direction_bit,
   input  wire logic                      scl_in,
   output logic                           scl_out,
   output logic                           scl_oe,
   input  wire logic                      sda_in,
   output logic                           sda_out,
   output logic                           sda_oe,
   output logic                           data_out,
   output logic                           data_out_oe,
   output logic [7:0]                     shift_data_register,
   output logic [3:0]                     edge_counter,
   output logic                           start_condition_flag,
   output logic                           overflow_flag,
   output logic [7:0]                     rx_data,
   output logic                           rx_valid,
   input  wire logic                      rx_ready
);
   logic                          scl_meta;
   logic                          scl_sync;
   logic                          scl_prev;
   logic                          sda_meta;
   logic                          sda_sync;
   logic                          sda_prev;
   logic                          scl_rise;
   logic                          scl_fall;
   logic                          sample_edge;
   logic                          change_edge;
   logic                          ext_clocked;
   logic                          two_wire;
   logic                          start_seen;
   logic                          wrap;
   logic                          out_latch;
   logic                          clock_port;
   logic                          push_pending;
   logic                          fifo_ready;
   logic                          hold_scl;
   serial_unit_pkg::start_state_t start_state;
   serial_unit_pkg::start_state_t next_start_state;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; no glitch filter on the bus lines
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   assign two_wire    = (wire_mode_select == serial_unit_pkg::MODE_TWO_WIRE);
   assign ext_clocked = clock_source_select && (wire_mode_select != serial_unit_pkg::MODE_OFF);
   assign scl_rise    = scl_sync && !scl_prev;
   assign scl_fall    = !scl_sync && scl_prev;
   // the bus edges seen here are those of the synchronised scl_in pin, taken only with clock_source_select set and a mode other than off
   assign sample_edge = ext_clocked && (negative_sample_edge ? scl_fall : scl_rise);
   assign change_edge = ext_clocked && (negative_sample_edge ? scl_rise : scl_fall);
   // start: data falls while the clock stays high, two-wire only
   assign start_seen  = two_wire && scl_sync && scl_prev && !sda_sync && sda_prev;
   assign wrap        = (sample_edge || change_edge) && (edge_counter == `COUNT_LAST_EDGE);
   // two-wire only stretch: start hold, overflow, or a byte the full fifo cannot take
   assign hold_scl    = two_wire && ((start_state == serial_unit_pkg::START_HOLD) || overflow_flag
                                     || (push_pending && !fifo_ready));
   // two-wire lines are only pulled low; three-wire drives the pins
   assign scl_out     = two_wire ? 1'b0 : clock_port;
   assign scl_oe      = two_wire ? (hold_scl || (clock_direction_bit && !clock_port)) : clock_direction_bit;
   assign sda_out     = 1'b0;
   assign sda_oe      = two_wire && data_direction_bit && (!out_latch || !data_port_bit);
   assign data_out    = out_latch;
   assign data_out_oe = (wire_mode_select == serial_unit_pkg::MODE_THREE_WIRE) && data_direction_bit;

   // software-paced bus clock pin
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         clock_port <= `PORT_BIT_RESET;
      else if (clock_port_write)
         clock_port <= clock_port_value;
      else if (clock_port_toggle)
         clock_port <= !clock_port;
   end

   ////////////////////////////////////////////////////////////////////////////
   // shift register and output latch
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_data_register <= `SHIFT_DATA_RESET;
      end
      else if (shift_load)
      begin
         shift_data_register <= shift_load_data;
      end
      else if (sample_edge)
      begin
         shift_data_register <= {shift_data_register[6:0], sda_sync};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_latch <= 1'b1;
      end
      else if (shift_load)
      begin
         out_latch <= shift_load_data[`DATA_MSB];
      end
      else if (change_edge)
      begin
         out_latch <= shift_data_register[`DATA_MSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge counter, both edges counted
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         edge_counter <= `COUNT_RESET;
      end
      else if (counter_load)
      begin
         edge_counter <= counter_load_value;
      end
      else if (sample_edge || change_edge)
      begin
         edge_counter <= edge_counter + 1'b1;
      end
   end

   // overflow flag: set wins over clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         overflow_flag <= 1'b0;
      end
      else if (wrap)
      begin
         overflow_flag <= 1'b1;
      end
      else if (overflow_flag_clear)
      begin
         overflow_flag <= 1'b0;
      end
   end

   // start flag: set wins over clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         start_condition_flag <= 1'b0;
      end
      else if (start_seen)
      begin
         start_condition_flag <= 1'b1;
      end
      else if (start_flag_clear)
      begin
         start_condition_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // start clock hold sequence
   always_comb
   begin
      next_start_state = start_state;
      case (start_state)
         serial_unit_pkg::START_IDLE:
         begin
            if (start_seen)
            begin
               next_start_state = serial_unit_pkg::START_WAIT_FALL;
            end
         end
         serial_unit_pkg::START_WAIT_FALL:
         begin
            if (!two_wire)
            begin
               next_start_state = serial_unit_pkg::START_IDLE;
            end
            else if (scl_fall)
            begin
               next_start_state = serial_unit_pkg::START_HOLD;
            end
         end
         serial_unit_pkg::START_HOLD:
         begin
            if (!two_wire || ((start_flag_clear || !start_condition_flag) && counter_load))
            begin
               next_start_state = serial_unit_pkg::START_IDLE;
            end
         end
         default:
         begin
            next_start_state = serial_unit_pkg::START_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         start_state <= serial_unit_pkg::START_IDLE;
      end
      else
      begin
         start_state <= next_start_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // received byte hand-off; in two-wire mode a full fifo keeps the clock stretched
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         push_pending <= 1'b0;
      end
      else if (wrap)
      begin
         push_pending <= 1'b1;
      end
      else if (fifo_ready)
      begin
         push_pending <= 1'b0;
      end
   end

   byte_fifo #(
      .WIDTH (`RX_FIFO_WIDTH),
      .DEPTH (`RX_FIFO_DEPTH)
   ) rx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (shift_data_register),
      .in_valid  (push_pending),
      .in_ready  (fifo_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );
endmodule

// *** sim/universal_serial_unit_assertions.sv ***
// concurrent checks on the universal serial unit ports
`timescale 1ns/100ps
module universal_serial_unit_assertions (
   input wire logic                   clk,
   input wire logic                   rst_n,
   input serial_unit_pkg::wire_mode_t wire_mode_select,
   input wire logic                   counter_load,
   input wire logic                   data_port_bit,
   input wire logic                   data_direction_bit,
   input wire logic                   scl_in,
   input wire logic                   scl_out,
   input wire logic                   scl_oe,
   input wire logic                   sda_in,
   input wire logic                   sda_out,
   input wire logic                   sda_oe,
   input wire logic [7:0]             shift_data_register,
   input wire logic [3:0]             edge_counter,
   input wire logic                   start_condition_flag,
   input wire logic                   overflow_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic two;
   assign two = wire_mode_select == serial_unit_pkg::MODE_TWO_WIRE;

   a_scl_pull_only: assert property (two && scl_oe |-> !scl_out)
      else $error("clock line driven high");
   a_sda_pull_only: assert property (two && sda_oe |-> !sda_out)
      else $error("data line driven high");
   a_sda_pull_low: assert property (two && data_direction_bit && !(shift_data_register[7] && data_port_bit)
      |-> ##[0:2] sda_oe) else $error("data line not pulled low");
   a_start_sets_flag: assert property (two && scl_in && $fell(sda_in) |-> ##[0:4] start_condition_flag)
      else $error("start condition missed");
   a_start_holds_clock: assert property (two && start_condition_flag && $fell(scl_in)
      |-> ##[0:3] (scl_oe && !scl_out)) else $error("clock not held after start");
   a_overflow_holds_clock: assert property (two && $rose(overflow_flag) |-> ##[0:3] (scl_oe && !scl_out))
      else $error("clock not held after overflow");
   a_overflow_at_wrap: assert property ($rose(overflow_flag) |-> edge_counter == 4'h0)
      else $error("overflow away from wrap");
   a_count_steps_one: assert property ($changed(edge_counter) && !$past(counter_load)
      |-> edge_counter == $past(edge_counter) + 4'h1) else $error("counter skipped");
endmodule

bind universal_serial_unit universal_serial_unit_assertions chk (.clk, .rst_n, .wire_mode_select, .counter_load,
   .data_port_bit, .data_direction_bit, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
   .shift_data_register, .edge_counter, .start_condition_flag, .overflow_flag);

// *** sim/two_wire_master_model.sv ***
// two-wire bus master model: open-drain pulls, software-paced clock
`timescale 1ns/100ps
module two_wire_master_model #(
   parameter int HALF = 4
) (
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low
);
   int   stretch_err = 0;
   logic seen;
   initial
   begin
      scl_low = 1'h0;
      sda_low = 1'h0;
   end
   task automatic wait_half();
      repeat (HALF) @(posedge clk);
   endtask
   // let the clock go, then wait (bounded) while a slave stretches it
   task automatic clock_up();
      int n;
      n = 0;
      scl_low <= 1'h0;
      @(posedge clk);
      while (!scl && n < 500)
      begin
         @(posedge clk);
         n++;
      end
      if (!scl)
         stretch_err++;
   endtask
   task automatic start();
      sda_low <= 1'h1;
      wait_half();
      scl_low <= 1'h1;
      wait_half();
   endtask
   task automatic put_bit(logic b);
      sda_low <= !b;
      wait_half();
      clock_up();
      wait_half();
      seen = sda;
      scl_low <= 1'h1;
      wait_half();
   endtask
   task automatic stop();
      sda_low <= 1'h1;
      wait_half();
      clock_up();
      wait_half();
      sda_low <= 1'h0;
      wait_half();
   endtask
endmodule

// *** sim/two_wire_shift_interface_bench.sv ***
// self-checking bench for the universal serial unit as two-wire slave
`timescale 1ns/100ps
module two_wire_shift_interface_bench;
   logic                        clk;
   logic                        rst_n = 1'h0;
   serial_unit_pkg::wire_mode_t mode = serial_unit_pkg::MODE_OFF;
   logic                        css = 1'h0, sl = 1'h0, cl = 1'h0, sfc = 1'h0, ofc = 1'h0;
   logic                        ddb = 1'h0, cpv = 1'h0, cdb = 1'h0, rdy = 1'h0;
   logic [3:0]                  clv = 4'h0;
   logic [7:0]                  sld = 8'h00;
   logic                        dout, dout_oe;
   logic [3:0]                  cnt;
   logic [7:0]                  sdr, rx_data;
   logic                        scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low, rx_valid, sof, ovf;
   wire                         scl = !(m_scl_low || (scl_oe && !scl_out));
   wire                         sda = !(m_sda_low || (sda_oe && !sda_out));
   int                          errors = 0;
   int                          n_tests = 0;
   int                          cycles = 0;

   initial
   begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   universal_serial_unit dut (.clk(clk), .rst_n(rst_n), .wire_mode_select(mode), .clock_source_select(css),
      .negative_sample_edge(1'h0), .shift_load_data(sld), .shift_load(sl), .counter_load_value(clv),
      .counter_load(cl), .start_flag_clear(sfc), .overflow_flag_clear(ofc), .data_port_bit(1'h1),
      .data_direction_bit(ddb), .clock_port_write(1'h0), .clock_port_value(cpv), .clock_port_toggle(1'h0),
      .clock_direction_bit(cdb), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .data_out(dout), .data_out_oe(dout_oe), .shift_data_register(sdr),
      .edge_counter(cnt), .start_condition_flag(sof), .overflow_flag(ovf), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rdy));

   two_wire_master_model #(.HALF(4)) m (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
      .sda_low(m_sda_low));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   // one-cycle software strobes, shift load included
   task automatic strobe(logic s, logic o, logic c, logic [3:0] v);
      sfc <= s;
      ofc <= o;
      cl <= c;
      clv <= v;
      @(posedge clk);
      {sfc, ofc, cl, sl} <= 4'h0;
      tick(3);
   endtask
   task automatic send_byte(logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         m.put_bit(b[i]);
      end
      tick(4);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(8);
      rst_n <= 1'h1;
      mode <= serial_unit_pkg::MODE_TWO_WIRE;
      {css, cpv, cdb, rdy} <= 4'hf;
      tick(4);
      m.start();
      check("start flag", sof, 1);
      check("clock held after start", {scl_oe, scl_out}, 2'h2);
      strobe(1, 0, 1, 4'h0);
      check("clock freed by clear", scl_oe, 0);
      send_byte(8'ha6);
      check("address shifted in", sdr, 8'ha6);
      check("overflow after sixteen edges", {ovf, cnt}, 5'h10);
      check("clock held after byte", {scl_oe, scl_out}, 2'h2);
      sl <= 1'h1;
      sld <= 8'h00;
      ddb <= 1'h1;
      strobe(0, 1, 1, 4'he);
      m.put_bit(1'h1);
      check("acknowledge low", m.seen, 0);
      check("no three-wire output", dout_oe, 0);
      tick(4);
      check("clock held after acknowledge", {ovf, scl_oe, scl_out}, 3'h6);
      ddb <= 1'h0;
      strobe(0, 1, 0, 4'h0);
      m.stop();
      $display("test address_and_acknowledge done");
      rdy <= 1'h0;
      m.start();
      strobe(1, 0, 1, 4'h0);
      for (int i = 0; i < 9; i++)
      begin
         send_byte(8'h30 + i);
         check("byte overflow", ovf, 1);
         strobe(0, 1, 0, 4'h0);
      end
      check("clock held while fifo full", {scl_oe, scl_out}, 2'h2);
      for (int i = 0; i < 9; i++)
      begin
         check("fifo word", {rx_valid, rx_data}, 9'h130 + i);
         rdy <= 1'h1;
         @(posedge clk);
         rdy <= 1'h0;
         tick(2);
      end
      m.stop();
      check("fifo drained", rx_valid, 0);
      check("clock stretch waits", m.stretch_err, 0);
      $display("test byte_stream_and_fifo done");
      tally_and_finish();
   end
endmodule
